// ==== rtl/pmcd_cfg.svh ====
// Command codes, reset values, field positions and timing counts of the command decoder
`ifndef PMCD_CFG_SVH
`define PMCD_CFG_SVH

// Command codes
`define PMCD_CMD_STORE_ALL      8'h15
`define PMCD_CMD_RESTORE_ALL    8'h16
`define PMCD_CMD_PEAK_CLEAR     8'he3
`define PMCD_CMD_LOG_SAVE       8'hea
`define PMCD_CMD_LOG_ERASE      8'hec
`define PMCD_CMD_IIN            8'hed
`define PMCD_CMD_LOG_BYTES      8'hee
`define PMCD_CMD_COMMON         8'hef
`define PMCD_CMD_COMPARE        8'hf0
`define PMCD_CMD_DIE_PEAK       8'hf4
`define PMCD_CMD_PHASING        8'hf5
`define PMCD_CMD_TEMPCO         8'hf6
`define PMCD_CMD_TSLOPE         8'hf8
`define PMCD_CMD_TOFFSET        8'hf9
`define PMCD_CMD_RAIL_ADDR      8'hfa
`define PMCD_CMD_SOFT_RESET     8'hfd
// Lowest code of the upper range owned by this decoder; writes there that are not accepted raise the fault
`define PMCD_CMD_RANGE_LO       8'he0

// Reset values
`define PMCD_RST_PHASING        8'h10
`define PMCD_RST_TEMPCO         16'h0f3c
`define PMCD_RST_TSLOPE         16'h4000
`define PMCD_RST_TOFFSET        16'h8000
`define PMCD_RST_RAIL_ADDR      8'h80

// Field positions
`define PMCD_CML_BIT            6
`define PMCD_PWM_RANGE_BIT      7
`define PMCD_L11_EXP_MSB        15
`define PMCD_L11_EXP_LSB        11
`define PMCD_L11_MAN_MSB        10
`define PMCD_L16_EXP            (-12)
`define PMCD_FIX_FRAC           16
`define PMCD_COM_LOCK_BIT       0
`define PMCD_COM_MISMATCH_BIT   1
`define PMCD_COM_CH0_OFF_BIT    2
`define PMCD_COM_CH1_OFF_BIT    3
`define PMCD_COM_NVM_BUSY_BIT   4

// Timing: retry interval counts in milliseconds
`define PMCD_CLK_MHZ            100
`define PMCD_TICK_US            1000
`define PMCD_TICK_CYC           (`PMCD_TICK_US * `PMCD_CLK_MHZ)
`define PMCD_LOG_LEN            8'h20

`endif

// ==== rtl/pmcd_pkg.sv ====
// Types shared by the power manager command decoder
`default_nettype none
package pmcd_pkg;

  typedef enum logic [2:0] {
    PMCD_FMT_L11 = 3'b001,
    PMCD_FMT_L16 = 3'b010,
    PMCD_FMT_I16 = 3'b100
  } pmcd_fmt_e;

  typedef enum logic [1:0] {
    PMCD_OC_IGNORE = 2'h0,
    PMCD_OC_LATCH  = 2'h1,
    PMCD_OC_RETRY  = 2'h2
  } pmcd_oc_resp_e;

  typedef enum logic [2:0] {
    PMCD_CH_ON    = 3'b001,
    PMCD_CH_LATCH = 3'b010,
    PMCD_CH_RETRY = 3'b100
  } pmcd_ch_e;

  typedef struct packed {
    logic [7:0]            phasing;
    logic [1:0][15:0]      tempco;
    logic [1:0][15:0]      tslope;
    logic [1:0][15:0]      toffset;
    logic [1:0][7:0]       rail_addr;
  } pmcd_nv_s;

  typedef struct packed {
    pmcd_nv_s              work;
    pmcd_nv_s              image;
    logic [15:0]           die_peak;
    logic                  peak_vld;
    logic                  log_lock;
    logic                  mismatch;
    logic [7:0]            log_idx;
    logic                  rd_valid;
    logic [15:0]           rd_data;
    logic                  log_save;
    logic                  log_erase;
    logic                  store_all;
    logic                  restore_all;
    logic                  compare;
    logic                  soft_rst;
    logic                  cml;
    logic [1:0]            ch_off;
    pmcd_ch_e [1:0]        ch_st;
    logic [1:0][15:0]      retry_cnt;
    logic [31:0]           tick_cnt;
    logic                  tick;
    logic [1:0]            ilim_hi;
    logic [1:0][2:0]       ilim_lvl;
    logic signed [47:0]    conv;
  } pmcd_state_s;

endpackage
`default_nettype wire

// ==== rtl/pmcd_top.sv ====
// Power manager command decoder: upper command set, formats and overcurrent response
`include "pmcd_cfg.svh"
`default_nettype none

module pmcd_top #(
  parameter int unsigned TICK_CYC = `PMCD_TICK_CYC,
  parameter int unsigned N_CH     = 2
) (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 cmd_valid_i,
  input  wire logic                 cmd_write_i,
  input  wire logic [7:0]           cmd_code_i,
  input  wire logic [15:0]          cmd_data_i,
  input  wire logic                 page_i,
  input  wire logic                 blk_next_i,
  input  wire logic [7:0]           fault_rec_byte_i,
  input  wire logic                 fault_off_i,
  input  wire logic                 nvm_busy_i,
  input  wire logic [1:0][15:0]     iin_word_i,
  input  wire logic [15:0]          die_temp_i,
  input  wire logic                 die_temp_valid_i,
  input  wire logic [1:0][7:0]      pwm_mode_i,
  input  wire logic [1:0][2:0]      oc_level_i,
  input  wire logic [1:0][1:0]      oc_resp_i,
  input  wire logic [1:0]           oc_fault_i,
  input  wire logic [15:0]          retry_ms_i,
  input  wire logic [15:0]          conv_word_i,
  input  wire logic [2:0]           conv_fmt_i,
  output logic                      rd_valid_o,
  output logic [15:0]               rd_data_o,
  output logic [7:0]                fault_rec_idx_o,
  output logic                      log_save_o,
  output logic                      log_erase_o,
  output logic                      store_all_o,
  output logic                      restore_all_o,
  output logic                      compare_o,
  output logic                      soft_rst_o,
  output logic                      cml_fault_o,
  output logic                      mismatch_o,
  output logic [7:0]                phasing_cfg_o,
  output logic [1:0][15:0]          tempco_o,
  output logic [1:0][15:0]          tslope_o,
  output logic [1:0][15:0]          toffset_o,
  output logic [1:0][7:0]           rail_addr_o,
  output logic [1:0]                ch_off_o,
  output logic [1:0]                ilim_hi_range_o,
  output logic [1:0][2:0]           ilim_level_o,
  output logic signed [47:0]        conv_fix_o
);

  // Channel logic is written for exactly two channels
  if (N_CH != 2) begin : g_bad_ch
    $error("pmcd_top serves exactly two channels");
  end
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("pmcd_top tick count must be at least one");
  end

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

  // Fixed point with 16 fraction bits, wide enough for every format
  function automatic logic signed [47:0] to_fix(input logic [15:0] w, input logic [2:0] fmt);
    logic signed [4:0]  e;
    logic signed [47:0] m;
    logic [5:0]         sh;
    e  = w[`PMCD_L11_EXP_MSB:`PMCD_L11_EXP_LSB];
    m  = 48'(signed'(w[`PMCD_L11_MAN_MSB:0]));
    sh = 6'(7'(signed'(e)) + 7'(`PMCD_FIX_FRAC));
    to_fix = '0;
    unique case (fmt)
      pmcd_pkg::PMCD_FMT_L11: to_fix = m <<< sh;
      pmcd_pkg::PMCD_FMT_L16: to_fix = 48'({32'h0, w}) <<<
                                       (`PMCD_FIX_FRAC + `PMCD_L16_EXP);
      pmcd_pkg::PMCD_FMT_I16: to_fix = 48'({32'h0, w}) <<< `PMCD_FIX_FRAC;
      default:                to_fix = '0;
    endcase
  endfunction

  // Power-on values of the stored settings
  function automatic pmcd_pkg::pmcd_nv_s nv_default();
    pmcd_pkg::pmcd_nv_s d;
    d.phasing   = `PMCD_RST_PHASING;
    d.tempco    = {2{`PMCD_RST_TEMPCO}};
    d.tslope    = {2{`PMCD_RST_TSLOPE}};
    d.toffset   = {2{`PMCD_RST_TOFFSET}};
    d.rail_addr = {2{`PMCD_RST_RAIL_ADDR}};
    return d;
  endfunction

  // Codes that accept a data write
  function automatic logic is_writable(input logic [7:0] c);
    return (c == `PMCD_CMD_PHASING) || (c == `PMCD_CMD_TEMPCO) ||
           (c == `PMCD_CMD_TSLOPE) || (c == `PMCD_CMD_TOFFSET) ||
           (c == `PMCD_CMD_RAIL_ADDR);
  endfunction

  // Codes that are pure send-byte events
  function automatic logic is_send(input logic [7:0] c);
    return (c == `PMCD_CMD_STORE_ALL) || (c == `PMCD_CMD_RESTORE_ALL) ||
           (c == `PMCD_CMD_PEAK_CLEAR) || (c == `PMCD_CMD_LOG_SAVE) ||
           (c == `PMCD_CMD_LOG_ERASE) || (c == `PMCD_CMD_COMPARE) ||
           (c == `PMCD_CMD_SOFT_RESET);
  endfunction

  pmcd_pkg::pmcd_state_s st_ff;
  pmcd_pkg::pmcd_state_s nxt_st;

  // Power-on state of every flop
  function automatic pmcd_pkg::pmcd_state_s st_reset();
    pmcd_pkg::pmcd_state_s s;
    s = '0;
    s.work  = nv_default();
    s.image = nv_default();
    s.ch_st[0] = pmcd_pkg::PMCD_CH_ON;
    s.ch_st[1] = pmcd_pkg::PMCD_CH_ON;
    return s;
  endfunction

  // Next-state logic of the whole decoder
  always_comb
  begin
    logic [7:0]  common;
    logic        pg;
    logic        wr_hit;
    logic        rd_hit;
    nxt_st = st_ff;
    common = '0;
    pg     = page_i;
    wr_hit = cmd_valid_i && cmd_write_i;
    rd_hit = cmd_valid_i && !cmd_write_i;

    // One-cycle event outputs fall back every cycle
    nxt_st.rd_valid    = 1'b0;
    nxt_st.log_save    = 1'b0;
    nxt_st.log_erase   = 1'b0;
    nxt_st.store_all   = 1'b0;
    nxt_st.restore_all = 1'b0;
    nxt_st.compare     = 1'b0;
    nxt_st.soft_rst    = 1'b0;
    nxt_st.cml         = 1'b0;

    // Millisecond tick for the retry timer
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt >= TICK_LAST)
    begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick     = 1'b1;
    end
    else
    begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;
    end

    // Family status byte
    common[`PMCD_COM_LOCK_BIT]     = st_ff.log_lock;
    common[`PMCD_COM_MISMATCH_BIT] = st_ff.mismatch;
    common[`PMCD_COM_CH0_OFF_BIT]  = st_ff.ch_off[0];
    common[`PMCD_COM_CH1_OFF_BIT]  = st_ff.ch_off[1];
    common[`PMCD_COM_NVM_BUSY_BIT] = nvm_busy_i;

    // Peak tracker; the first sample after a clear always loads
    if (die_temp_valid_i && (!st_ff.peak_vld ||
        to_fix(die_temp_i, pmcd_pkg::PMCD_FMT_L11) >
        to_fix(st_ff.die_peak, pmcd_pkg::PMCD_FMT_L11)))
    begin
      nxt_st.die_peak = die_temp_i;
      nxt_st.peak_vld = 1'b1;
    end

    // A channel faulting off locks the log in the same cycle as an automatic save
    if (fault_off_i && !st_ff.log_lock)
    begin
      nxt_st.log_save = 1'b1;
      nxt_st.log_lock = 1'b1;
    end

    // Format conversion service
    nxt_st.conv = to_fix(conv_word_i, conv_fmt_i);

    // Current limit range follows the channel mode byte, level follows oc_level_i
    for (int c = 0; c < 2; c++)
    begin
      nxt_st.ilim_hi[c]  = pwm_mode_i[c][`PMCD_PWM_RANGE_BIT];
      nxt_st.ilim_lvl[c] = oc_level_i[c];
    end

    // Overcurrent response per channel
    for (int c = 0; c < 2; c++)
    begin
      unique case (st_ff.ch_st[c])
        pmcd_pkg::PMCD_CH_ON:
        begin
          nxt_st.ch_off[c] = 1'b0;
          if (oc_fault_i[c] && oc_resp_i[c] == pmcd_pkg::PMCD_OC_LATCH)
          begin
            nxt_st.ch_st[c]  = pmcd_pkg::PMCD_CH_LATCH;
            nxt_st.ch_off[c] = 1'b1;
          end
          else if (oc_fault_i[c] && oc_resp_i[c] == pmcd_pkg::PMCD_OC_RETRY)
          begin
            nxt_st.ch_st[c]     = pmcd_pkg::PMCD_CH_RETRY;
            nxt_st.ch_off[c]    = 1'b1;
            nxt_st.retry_cnt[c] = retry_ms_i;
          end
        end
        pmcd_pkg::PMCD_CH_LATCH:
        begin
          nxt_st.ch_off[c] = 1'b1;
        end
        pmcd_pkg::PMCD_CH_RETRY:
        begin
          // Retries never run out; the free-running tick can make each wait up to one tick short of the interval
          nxt_st.ch_off[c] = 1'b1;
          if (st_ff.retry_cnt[c] == 16'h0)
          begin
            nxt_st.ch_st[c]  = pmcd_pkg::PMCD_CH_ON;
            nxt_st.ch_off[c] = 1'b0;
          end
          else if (st_ff.tick)
          begin
            nxt_st.retry_cnt[c] = st_ff.retry_cnt[c] - 16'h1;
          end
        end
        default:
        begin
          nxt_st.ch_st[c]  = pmcd_pkg::PMCD_CH_ON;
          nxt_st.ch_off[c] = 1'b0;
        end
      endcase
    end

    // Block read continues from the current record index
    if (blk_next_i)
    begin
      nxt_st.rd_valid = 1'b1;
      nxt_st.rd_data  = {8'h0, fault_rec_byte_i};
      nxt_st.log_idx  = st_ff.log_idx + 8'h1;
    end

    // Reads: unknown codes answer zero and touch nothing
    if (rd_hit)
    begin
      nxt_st.rd_valid = 1'b1;
      nxt_st.rd_data  = 16'h0;
      unique case (cmd_code_i)
        `PMCD_CMD_IIN:       nxt_st.rd_data = iin_word_i[pg];
        `PMCD_CMD_LOG_BYTES:
        begin
          nxt_st.rd_data = {8'h0, `PMCD_LOG_LEN};
          nxt_st.log_idx = 8'h0;
        end
        `PMCD_CMD_COMMON:    nxt_st.rd_data = {8'h0, common};
        `PMCD_CMD_DIE_PEAK:  nxt_st.rd_data = st_ff.die_peak;
        `PMCD_CMD_PHASING:   nxt_st.rd_data = {8'h0, st_ff.work.phasing};
        `PMCD_CMD_TEMPCO:    nxt_st.rd_data = st_ff.work.tempco[pg];
        `PMCD_CMD_TSLOPE:    nxt_st.rd_data = st_ff.work.tslope[pg];
        `PMCD_CMD_TOFFSET:   nxt_st.rd_data = st_ff.work.toffset[pg];
        `PMCD_CMD_RAIL_ADDR: nxt_st.rd_data = {8'h0, st_ff.work.rail_addr[pg]};
        default:             nxt_st.rd_data = 16'h0;
      endcase
    end

    // Data writes to the stored settings
    if (wr_hit && is_writable(cmd_code_i))
    begin
      unique case (cmd_code_i)
        `PMCD_CMD_PHASING:   nxt_st.work.phasing = cmd_data_i[7:0];
        `PMCD_CMD_TEMPCO:    nxt_st.work.tempco[pg] = cmd_data_i;
        `PMCD_CMD_TSLOPE:    nxt_st.work.tslope[pg] = cmd_data_i;
        `PMCD_CMD_TOFFSET:   nxt_st.work.toffset[pg] = cmd_data_i;
        `PMCD_CMD_RAIL_ADDR: nxt_st.work.rail_addr[pg] = cmd_data_i[7:0];
        default:             nxt_st.work = st_ff.work;
      endcase
    end
    // Writes to read-only or foreign codes in our range only raise the fault
    else if (wr_hit && !is_send(cmd_code_i) && cmd_code_i >= `PMCD_CMD_RANGE_LO)
    begin
      nxt_st.cml = 1'b1;
    end

    // Send-byte events
    if (wr_hit && is_send(cmd_code_i))
    begin
      unique case (cmd_code_i)
        `PMCD_CMD_LOG_SAVE:
        begin
          nxt_st.log_save = 1'b1;
          nxt_st.log_lock = 1'b1;
        end
        `PMCD_CMD_LOG_ERASE:
        begin
          // An automatic save in this same cycle keeps the lock
          nxt_st.log_erase = 1'b1;
          nxt_st.log_lock  = fault_off_i && !st_ff.log_lock;
        end
        `PMCD_CMD_COMPARE:
        begin
          nxt_st.compare  = 1'b1;
          nxt_st.mismatch = (st_ff.work != st_ff.image);
        end
        `PMCD_CMD_STORE_ALL:
        begin
          nxt_st.store_all = 1'b1;
          nxt_st.image     = st_ff.work;
        end
        `PMCD_CMD_RESTORE_ALL:
        begin
          nxt_st.restore_all = 1'b1;
          nxt_st.work        = st_ff.image;
        end
        `PMCD_CMD_PEAK_CLEAR:
        begin
          // A sample landing with the clear is kept, so no peak is lost
          nxt_st.peak_vld = die_temp_valid_i;
          nxt_st.die_peak = die_temp_valid_i ? die_temp_i : 16'h0;
        end
        `PMCD_CMD_SOFT_RESET:
        begin
          // Full restart: stored image and log lock survive, as they would in NVM
          nxt_st             = st_reset();
          nxt_st.image       = st_ff.image;
          nxt_st.work        = st_ff.image;
          nxt_st.log_lock    = st_ff.log_lock || fault_off_i;
          nxt_st.log_save    = fault_off_i && !st_ff.log_lock;
          nxt_st.soft_rst    = 1'b1;
        end
        default:
        begin
          nxt_st.cml = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_ff <= st_reset();
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a flop of the state
  assign rd_valid_o      = st_ff.rd_valid;
  assign rd_data_o       = st_ff.rd_data;
  assign fault_rec_idx_o = st_ff.log_idx;
  assign log_save_o      = st_ff.log_save;
  assign log_erase_o     = st_ff.log_erase;
  assign store_all_o     = st_ff.store_all;
  assign restore_all_o   = st_ff.restore_all;
  assign compare_o       = st_ff.compare;
  assign soft_rst_o      = st_ff.soft_rst;
  assign cml_fault_o     = st_ff.cml;
  assign mismatch_o      = st_ff.mismatch;
  assign phasing_cfg_o   = st_ff.work.phasing;
  assign tempco_o        = st_ff.work.tempco;
  assign tslope_o        = st_ff.work.tslope;
  assign toffset_o       = st_ff.work.toffset;
  assign rail_addr_o     = st_ff.work.rail_addr;
  assign ch_off_o        = st_ff.ch_off;
  assign ilim_hi_range_o = st_ff.ilim_hi;
  assign ilim_level_o    = st_ff.ilim_lvl;
  assign conv_fix_o      = st_ff.conv;

endmodule

`default_nettype wire

// ==== tb/pmcd_top_props.sv ====
// Concurrent checks on the decoder's command port and overcurrent outputs
`default_nettype none
module pmcd_top_props (
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic             cmd_valid_i,
  input wire logic             cmd_write_i,
  input wire logic [7:0]       cmd_code_i,
  input wire logic [15:0]      cmd_data_i,
  input wire logic             page_i,
  input wire logic [1:0][1:0]  oc_resp_i,
  input wire logic [1:0]       oc_fault_i,
  input wire logic             rd_valid_o,
  input wire logic             log_save_o,
  input wire logic             compare_o,
  input wire logic             soft_rst_o,
  input wire logic             cml_fault_o,
  input wire logic [1:0][15:0] tempco_o,
  input wire logic [1:0]       ch_off_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Taken writes and reads
  logic wr_q;
  logic rd_q;
  assign wr_q = cmd_valid_i && cmd_write_i;
  assign rd_q = cmd_valid_i && !cmd_write_i;

  a_read_answer: assert property (rd_q |=> rd_valid_o)
    else $error("read not answered in the next cycle");
  a_log_save: assert property (wr_q && cmd_code_i == 8'hea |=> log_save_o)
    else $error("log save command gave no save pulse");
  a_compare_pulse: assert property (wr_q && cmd_code_i == 8'hf0 |=> compare_o)
    else $error("compare command gave no compare pulse");
  a_soft_reset: assert property (wr_q && cmd_code_i == 8'hfd |=> soft_rst_o)
    else $error("reset command gave no reset pulse");
  a_ro_write_flag: assert property (wr_q && cmd_code_i inside {8'hed, 8'hee, 8'hef, 8'hf4}
    |=> cml_fault_o)
    else $error("write to read-only code not flagged");
  a_cml_cause: assert property (cml_fault_o |-> $past(wr_q))
    else $error("communication fault without a write");
  a_tempco_write: assert property (wr_q && cmd_code_i == 8'hf6
    |=> tempco_o[$past(page_i)] == $past(cmd_data_i))
    else $error("tempco word not written to selected page");
  a_latch_off: assert property (oc_fault_i[0] && oc_resp_i[0] == 2'h1 |=> ch_off_o[0])
    else $error("latch response did not shut channel");
  a_latch_hold: assert property (ch_off_o[0] && oc_resp_i[0] == 2'h1 && !wr_q
    |=> ch_off_o[0])
    else $error("latched channel came back on");
  a_ignore_fault: assert property (oc_resp_i[0] == 2'h0 && !ch_off_o[0] |=> !ch_off_o[0])
    else $error("ignore response shut channel");

  // Main scenarios reached
  c_log_save: cover property (log_save_o);
  c_cml: cover property (cml_fault_o);
  c_ch_off: cover property ($rose(ch_off_o[0]));
endmodule

bind pmcd_top pmcd_top_props pmcd_top_props_i (
  .clk_i, .nrst_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_data_i, .page_i,
  .oc_resp_i, .oc_fault_i, .rd_valid_o, .log_save_o, .compare_o, .soft_rst_o,
  .cml_fault_o, .tempco_o, .ch_off_o
);
`default_nettype wire

// ==== tb/pmcd_host.sv ====
// Host model issuing decoder commands and block fetches
`default_nettype none
module pmcd_host (
  input  wire logic  clk_i,
  output logic       cmd_valid_o,
  output logic       cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_data_o,
  output logic       page_o,
  output logic       blk_next_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_data_o  = 16'h0000;
    page_o      = 1'b0;
    blk_next_o  = 1'b0;
  end

  // One command, held through the taking edge; data scrambled after release
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic p);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_code_o  <= c; // Writes only ever go to published codes
    cmd_data_o  <= d;
    page_o      <= p;
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_data_o  <= ~d; // Stale data would hide a late sample
  endtask

  // One record byte fetch; record is gathered byte by byte
  task automatic fetch();
    @(posedge clk_i);
    blk_next_o <= 1'b1;
    @(posedge clk_i);
    blk_next_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the power manager command decoder
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Inputs, all valued at time zero
  logic             clk_i            = 1'b0;
  logic             nrst_i           = 1'b0;
  logic             cmd_valid_i, cmd_write_i, page_i, blk_next_i;
  logic [7:0]       cmd_code_i;
  logic [15:0]      cmd_data_i;
  logic [7:0]       fault_rec_byte_i = 8'h5a;
  logic             fault_off_i      = 1'b0;
  logic             nvm_busy_i       = 1'b0;
  logic [1:0][15:0] iin_word_i       = 32'hd3ff_0000;
  logic [15:0]      die_temp_i       = 16'h0000;
  logic             die_temp_valid_i = 1'b0;
  logic [1:0][7:0]  pwm_mode_i       = 16'h0080;
  logic [1:0][2:0]  oc_level_i       = 6'h05;
  logic [1:0][1:0]  oc_resp_i        = 4'h9; // Ch1 retry, ch0 latch off
  logic [1:0]       oc_fault_i       = 2'h0;
  logic [15:0]      retry_ms_i       = 16'h0002;
  logic [15:0]      conv_word_i      = 16'h0000;
  logic [2:0]       conv_fmt_i       = 3'h1;
  // Outputs
  logic             rd_valid_o, log_save_o, log_erase_o, compare_o;
  logic             soft_rst_o, cml_fault_o, mismatch_o;
  logic [15:0]      rd_data_o;
  logic [7:0]       fault_rec_idx_o;
  logic [1:0]       ch_off_o, ilim_hi_range_o;
  logic             store_all_o, restore_all_o;
  logic [7:0]       phasing_cfg_o;
  logic [1:0][15:0] tempco_o, tslope_o, toffset_o;
  logic [1:0][7:0]  rail_addr_o;
  logic [1:0][2:0]  ilim_level_o;
  logic signed [47:0] conv_fix_o;
  int               n_mismatch = 0;
  int               checks     = 0;
  // Conversion table: L11, negative L11, L16, integer word
  logic [15:0]      cw[4] = '{16'h9807, 16'h07ff, 16'h4c00, 16'h9807};
  logic [2:0]       cf[4] = '{3'h1, 3'h1, 3'h2, 3'h4};
  logic [47:0]      ce[4] = '{48'd56, 48'hffff_ffff_0000, 48'd311296, 48'h0000_9807_0000};

  // Short ms tick keeps retry waits small
  pmcd_top #(.TICK_CYC(4)) pmcd_top_i (
    .clk_i, .nrst_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_data_i, .page_i,
    .blk_next_i, .fault_rec_byte_i, .fault_off_i, .nvm_busy_i, .iin_word_i, .die_temp_i,
    .die_temp_valid_i, .pwm_mode_i, .oc_level_i, .oc_resp_i, .oc_fault_i, .retry_ms_i,
    .conv_word_i, .conv_fmt_i, .rd_valid_o, .rd_data_o, .fault_rec_idx_o, .log_save_o,
    .log_erase_o, .store_all_o, .restore_all_o, .compare_o, .soft_rst_o, .cml_fault_o,
    .mismatch_o, .phasing_cfg_o, .tempco_o, .tslope_o, .toffset_o, .rail_addr_o,
    .ch_off_o, .ilim_hi_range_o, .ilim_level_o, .conv_fix_o
  );
  pmcd_host pmcd_host_i (
    .clk_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i),
    .cmd_data_o(cmd_data_i), .page_o(page_i), .blk_next_o(blk_next_i)
  );

  // Clock and hang guard
  always #5 clk_i = ~clk_i;
  initial
  begin
    #20us;
    n_mismatch++;
    wrap_up();
  end

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read answers right after the taking edge
  task automatic rd(input logic [7:0] c, input logic p, input logic [15:0] e);
    pmcd_host_i.send(1'b0, c, 16'h0000, p);
    #1;
    cmp(48'(rd_valid_o), 48'h1);
    cmp(48'(rd_data_o), 48'(e));
  endtask
  task automatic wr(input logic [7:0] c, input logic p, input logic [15:0] d);
    pmcd_host_i.send(1'b1, c, d, p);
    #1;
  endtask
  task automatic samp(input logic [15:0] v);
    @(posedge clk_i);
    die_temp_i       <= v;
    die_temp_valid_i <= 1'b1;
    @(posedge clk_i);
    die_temp_valid_i <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(8'hf5, 1'b0, 16'h0010);
    for (int p = 0; p < 2; p++)
    begin
      rd(8'hf6, p[0], 16'h0f3c);
      rd(8'hf8, p[0], 16'h4000);
      rd(8'hf9, p[0], 16'h8000);
      rd(8'hfa, p[0], 16'h0080);
    end
    wr(8'hf5, 1'b0, 16'h00a5);
    cmp(48'(phasing_cfg_o), 48'h00a5);
    rd(8'hf5, 1'b0, 16'h00a5);
    wr(8'hf6, 1'b1, 16'h1234);
    cmp(48'(tempco_o), 48'h1234_0f3c);
    rd(8'hf6, 1'b0, 16'h0f3c);
    wr(8'hf9, 1'b1, 16'h0123);
    cmp(48'(toffset_o), 48'h0123_8000);
    // Store, disturb, compare, restore
    wr(8'h15, 1'b0, 16'h0000);
    cmp(48'(store_all_o), 48'h1);
    wr(8'hfa, 1'b0, 16'h0033);
    cmp(48'(rail_addr_o), 48'h8033);
    wr(8'hf0, 1'b0, 16'h0000);
    cmp(48'(mismatch_o), 48'h1);
    wr(8'h16, 1'b0, 16'h0000);
    cmp(48'(restore_all_o), 48'h1);
    rd(8'hfa, 1'b0, 16'h0080);
    rd(8'hf6, 1'b1, 16'h1234);
    wr(8'hf0, 1'b0, 16'h0000);
    cmp(48'(mismatch_o), 48'h0);
    wr(8'hf8, 1'b0, 16'h1111);
    cmp(48'(tslope_o), 48'h4000_1111);
    wr(8'hfd, 1'b0, 16'h0000);
    cmp(48'(soft_rst_o), 48'h1);
    rd(8'hf8, 1'b0, 16'h4000);
    wr(8'hef, 1'b0, 16'h00ff);
    cmp(48'(cml_fault_o), 48'h1);
    rd(8'he1, 1'b0, 16'h0000);
    // Fault log lock, erase and block read
    wr(8'hea, 1'b0, 16'h0000);
    cmp(48'(log_save_o), 48'h1);
    rd(8'hef, 1'b0, 16'h0001);
    wr(8'hec, 1'b0, 16'h0000);
    cmp(48'(log_erase_o), 48'h1);
    rd(8'hef, 1'b0, 16'h0000);
    // A channel faulting off saves the log by itself
    @(posedge clk_i);
    fault_off_i <= 1'b1;
    @(posedge clk_i);
    fault_off_i <= 1'b0;
    #1;
    cmp(48'(log_save_o), 48'h1);
    rd(8'hee, 1'b0, 16'h0020);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_i);
      fault_rec_byte_i <= 8'h5a + 8'(i);
      pmcd_host_i.fetch();
      #1;
      cmp(48'(rd_data_o), 48'h5a + 48'(i));
      cmp(48'(fault_rec_idx_o), 48'(i + 1));
    end
    rd(8'hed, 1'b1, 16'hd3ff);
    samp(16'h0010);
    samp(16'h0008);
    rd(8'hf4, 1'b0, 16'h0010);
    wr(8'he3, 1'b0, 16'h0000);
    rd(8'hf4, 1'b0, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      conv_word_i <= cw[i];
      conv_fmt_i  <= cf[i];
      @(posedge clk_i);
      #1;
      cmp(conv_fix_o, ce[i]);
    end
    cmp(48'(ilim_hi_range_o), 48'h1);
    cmp(48'(ilim_level_o), 48'h05);
    @(posedge clk_i);
    pwm_mode_i <= 16'h8000;
    oc_level_i <= 6'h38;
    oc_fault_i <= 2'h3;
    nvm_busy_i <= 1'b1;
    @(posedge clk_i);
    oc_fault_i <= 2'h0;
    #1;
    cmp(48'(ch_off_o), 48'h3);
    cmp(48'(ilim_hi_range_o), 48'h2);
    cmp(48'(ilim_level_o), 48'h38);
    rd(8'hef, 1'b0, 16'h001d);
    repeat (30) @(posedge clk_i);
    #1;
    cmp(48'(ch_off_o), 48'h1);
    wr(8'hfd, 1'b0, 16'h0000);
    cmp(48'(ch_off_o), 48'h0);
    @(posedge clk_i);
    oc_resp_i  <= 4'h0;
    oc_fault_i <= 2'h3;
    @(posedge clk_i);
    oc_fault_i <= 2'h0;
    #1;
    cmp(48'(ch_off_o), 48'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
